// ---- master_clock_gate_wake.sv ----
`timescale 1ns/100ps
module master_clock_gate_wake #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [clock_gate_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [clock_gate_pkg::DATA_W-1:0] avs_writedata,
    output logic [clock_gate_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_irq_a_pin_n,
    input wire logic ext_irq_b_pin_n,
    input wire logic hw_reset_pin_n,
    input wire logic wake_request_pin_i,
    output logic wake_request_pin_o,
    output logic wake_request_pin_oe,
    input wire logic rtc_alarm,
    input wire logic rtc_periodic,
    output logic master_clock_run,
    output logic [clock_gate_pkg::PERIPH_W-1:0] periph_gate
);
    import clock_gate_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bus_state_t bus_state;
    logic gate;
    logic [WAKE_CTRL_W-1:0] wake_ctrl;
    logic [DATA_W-1:0] next_readdata;
    logic request;
    logic commit_write;
    logic hit_cfg;
    logic hit_ctrl;
    logic hit_status;

    wake_if w ();

    // ------------------------------------------------------------
    // wake sensing
    // ------------------------------------------------------------
    assign w.ext_irq_a_pin_n = ext_irq_a_pin_n;
    assign w.ext_irq_b_pin_n = ext_irq_b_pin_n;
    assign w.wake_request_pin = wake_request_pin_i;
    assign w.hw_reset_pin_n = hw_reset_pin_n;
    assign w.rtc_alarm = rtc_alarm;
    assign w.rtc_periodic = rtc_periodic;
    assign w.alarm_en = wake_ctrl[ALARM_EN_BIT];
    assign w.periodic_en = wake_ctrl[PERIODIC_EN_BIT];

    wake_sense #(
        .SYNC_STAGES(SYNC_STAGES)
    ) u_sense (
        .clk(clk),
        .rst(rst),
        .w(w)
    );

    // ------------------------------------------------------------
    // avalon slave handshake
    // ------------------------------------------------------------
    assign request = avs_read | avs_write;
    assign avs_waitrequest = request & (bus_state == BUS_IDLE);
    assign commit_write = avs_write & (bus_state == BUS_ACK);
    assign hit_cfg = reg_hit(avs_address, CLOCK_GATE_CONFIG_IDX);
    assign hit_ctrl = reg_hit(avs_address, WAKE_CTRL_IDX);
    assign hit_status = reg_hit(avs_address, WAKE_STATUS_IDX);

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_state <= BUS_IDLE;
        end else begin
            unique case (bus_state)
                BUS_IDLE: begin
                    if (request) begin
                        bus_state <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read mux, unmapped reads give zero
    // ------------------------------------------------------------
    always_comb begin
        next_readdata = '0;
        if (hit_cfg) begin
            next_readdata[GATE_BIT] = gate;
            next_readdata[PERIPH_W-1:0] = periph_gate;
        end else if (hit_ctrl) begin
            next_readdata[WAKE_CTRL_W-1:0] = wake_ctrl;
        end else if (hit_status) begin
            next_readdata[ST_IRQ_A_BIT] = w.irq_a_level;
            next_readdata[ST_IRQ_B_BIT] = w.irq_b_level;
            next_readdata[ST_WAKE_PIN_BIT] = w.wake_level;
            next_readdata[ST_HW_RESET_BIT] = w.hw_reset_level;
            next_readdata[ST_ALARM_BIT] = w.alarm_level;
            next_readdata[ST_PERIODIC_BIT] = w.periodic_level;
            next_readdata[ST_ANY_BIT] = w.wake_any;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (avs_read & (bus_state == BUS_IDLE)) begin
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------
    // master clock gate bit
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            gate <= 1'b0;
        end else if (w.wake_any) begin
            gate <= 1'b0;
        end else if (commit_write & hit_cfg) begin
            gate <= avs_writedata[GATE_BIT];
        end
    end

    assign master_clock_run = ~gate;

    // ------------------------------------------------------------
    // peripheral gate bits
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            periph_gate <= PERIPH_GATE_RESET;
        end else if (commit_write & hit_cfg) begin
            periph_gate <= avs_writedata[PERIPH_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // wake pin direction and rtc enables
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_ctrl <= WAKE_CTRL_RESET;
        end else if (commit_write & hit_ctrl) begin
            wake_ctrl <= avs_writedata[WAKE_CTRL_W-1:0];
        end
    end

    assign wake_request_pin_oe = wake_ctrl[WAKE_DIR_BIT];
    assign wake_request_pin_o = wake_ctrl[WAKE_OUT_BIT];

endmodule

// ---- clock_gate_pkg.sv ----
package clock_gate_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CLOCK_GATE_CONFIG_IDX = 16'h1c02;
    localparam logic [ADDR_W-1:0] WAKE_CTRL_IDX = 16'h1c03;
    localparam logic [ADDR_W-1:0] WAKE_STATUS_IDX = 16'h1c04;

    // ------------------------------------------------------------
    // clock_gate_config fields
    // ------------------------------------------------------------
    localparam int GATE_BIT = 15;
    localparam int PERIPH_W = 15;
    localparam logic [PERIPH_W-1:0] PERIPH_GATE_RESET = 15'h0000;

    // ------------------------------------------------------------
    // wake_ctrl fields
    // ------------------------------------------------------------
    localparam int WAKE_DIR_BIT = 0;
    localparam int WAKE_OUT_BIT = 1;
    localparam int ALARM_EN_BIT = 2;
    localparam int PERIODIC_EN_BIT = 3;
    localparam int WAKE_CTRL_W = 4;
    localparam logic [WAKE_CTRL_W-1:0] WAKE_CTRL_RESET = 4'h0;

    // ------------------------------------------------------------
    // wake_status fields
    // ------------------------------------------------------------
    localparam int ST_IRQ_A_BIT = 0;
    localparam int ST_IRQ_B_BIT = 1;
    localparam int ST_WAKE_PIN_BIT = 2;
    localparam int ST_HW_RESET_BIT = 3;
    localparam int ST_ALARM_BIT = 4;
    localparam int ST_PERIODIC_BIT = 5;
    localparam int ST_ANY_BIT = 6;

    // ------------------------------------------------------------
    // bus answer states
    // ------------------------------------------------------------
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] idx);
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = {idx[ADDR_W-3:0], 2'b00};
        return addr == byte_addr;
    endfunction

endpackage

// ---- wake_if.sv ----
`timescale 1ns/100ps
interface wake_if;
    // raw pin levels, asynchronous to clk
    logic ext_irq_a_pin_n;
    logic ext_irq_b_pin_n;
    logic wake_request_pin;
    logic hw_reset_pin_n;
    // same-domain rtc events and their enables
    logic rtc_alarm;
    logic rtc_periodic;
    logic alarm_en;
    logic periodic_en;
    // synchronised pin levels, enable-qualified rtc levels, and wake_any
    logic irq_a_level;
    logic irq_b_level;
    logic wake_level;
    logic hw_reset_level;
    logic alarm_level;
    logic periodic_level;
    logic wake_any;

    modport sense (
        input ext_irq_a_pin_n, ext_irq_b_pin_n, wake_request_pin, hw_reset_pin_n,
        input rtc_alarm, rtc_periodic, alarm_en, periodic_en,
        output irq_a_level, irq_b_level, wake_level, hw_reset_level,
        output alarm_level, periodic_level, wake_any
    );

    modport ctrl (
        output ext_irq_a_pin_n, ext_irq_b_pin_n, wake_request_pin, hw_reset_pin_n,
        output rtc_alarm, rtc_periodic, alarm_en, periodic_en,
        input irq_a_level, irq_b_level, wake_level, hw_reset_level,
        input alarm_level, periodic_level, wake_any
    );
endinterface

// ---- wake_sense.sv ----
`timescale 1ns/100ps
module wake_sense #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    wake_if.sense w
);
    import clock_gate_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers, active levels as ones
    // ------------------------------------------------------------
    logic [SYNC_STAGES-1:0] sync_a;
    logic [SYNC_STAGES-1:0] sync_b;
    logic [SYNC_STAGES-1:0] sync_w;
    logic [SYNC_STAGES-1:0] sync_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_w <= '0;
            sync_r <= '0;
        end else begin
            sync_a <= {sync_a[SYNC_STAGES-2:0], ~w.ext_irq_a_pin_n};
            sync_b <= {sync_b[SYNC_STAGES-2:0], ~w.ext_irq_b_pin_n};
            sync_w <= {sync_w[SYNC_STAGES-2:0], w.wake_request_pin};
            sync_r <= {sync_r[SYNC_STAGES-2:0], ~w.hw_reset_pin_n};
        end
    end

    // ------------------------------------------------------------
    // level qualification, no edge detection
    // ------------------------------------------------------------
    assign w.irq_a_level = sync_a[SYNC_STAGES-1];
    assign w.irq_b_level = sync_b[SYNC_STAGES-1];
    assign w.wake_level = sync_w[SYNC_STAGES-1];
    assign w.hw_reset_level = sync_r[SYNC_STAGES-1];
    assign w.alarm_level = w.rtc_alarm & w.alarm_en;
    assign w.periodic_level = w.rtc_periodic & w.periodic_en;
    // only the listed sources can wake
    assign w.wake_any = w.irq_a_level | w.irq_b_level | w.wake_level | w.hw_reset_level
        | w.alarm_level | w.periodic_level;

endmodule

// ---- master_clock_gate_wake_properties.sv ----
`timescale 1ns/100ps
module master_clock_gate_wake_properties #(
    parameter int SYNC_STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] avs_address,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic ext_irq_a_pin_n,
    input wire logic ext_irq_b_pin_n,
    input wire logic hw_reset_pin_n,
    input wire logic wake_request_pin_i,
    input wire logic rtc_alarm,
    input wire logic rtc_periodic,
    input wire logic master_clock_run
);
    logic wr_cfg;
    logic pin_any;
    assign wr_cfg = avs_write && !avs_waitrequest && avs_address == 16'h7008;
    assign pin_any = !ext_irq_a_pin_n || !ext_irq_b_pin_n || !hw_reset_pin_n || wake_request_pin_i;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence quiet3;
        (!pin_any && !rtc_alarm && !rtc_periodic)[*3];
    endsequence
    sequence set_gate;
        wr_cfg && avs_writedata[15];
    endsequence
    chk_write_stops: assert property (quiet3 ##0 set_gate |=> !master_clock_run)
        else $error("gate write did not stop clock");
    chk_stop_cause: assert property ($fell(master_clock_run) |-> $past(wr_cfg))
        else $error("clock stopped without write");
    chk_wake_beats_write: assert property ((!ext_irq_b_pin_n)[*3] ##0 set_gate |=> master_clock_run)
        else $error("write beat wake level");
    chk_irq_a_wake: assert property ((!ext_irq_a_pin_n)[*3] |=> master_clock_run)
        else $error("irq a level did not wake");
    chk_irq_b_wake: assert property ((!ext_irq_b_pin_n)[*3] |=> master_clock_run)
        else $error("irq b level did not wake");
    chk_pin_wake: assert property (wake_request_pin_i[*3] |=> master_clock_run)
        else $error("wake pin did not wake");
    chk_hwrst_wake: assert property ((!hw_reset_pin_n)[*3] |=> master_clock_run)
        else $error("reset pin did not wake");
    chk_only_listed: assert property ($rose(master_clock_run) |->
        $past(rst) || $past(rtc_alarm || rtc_periodic) || $past(pin_any, 3) || $past(wr_cfg))
        else $error("clock restarted without cause");
endmodule
bind master_clock_gate_wake master_clock_gate_wake_properties #(.SYNC_STAGES(SYNC_STAGES)) u_props (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .ext_irq_a_pin_n(ext_irq_a_pin_n), .ext_irq_b_pin_n(ext_irq_b_pin_n),
    .hw_reset_pin_n(hw_reset_pin_n), .wake_request_pin_i(wake_request_pin_i), .rtc_alarm(rtc_alarm),
    .rtc_periodic(rtc_periodic), .master_clock_run(master_clock_run));

// ---- wake_party_model.sv ----
`timescale 1ns/100ps
module wake_party_model (
    input wire logic [3:0] src_on,
    input wire logic [1:0] rtc_on,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic irq_a_n,
    output logic irq_b_n,
    output logic hw_n,
    output logic pad,
    output logic alarm,
    output logic periodic
);
    // sources are levels held while asked, never edges
    assign irq_a_n = !src_on[0];
    assign irq_b_n = !src_on[1];
    assign hw_n = !src_on[3];
    // outside holds the pad low unless waking; device drive wins when enabled
    assign pad = pin_oe ? pin_out : src_on[2];
    assign {periodic, alarm} = rtc_on;
endmodule

// ---- master_clock_gate_wake_tb_top.sv ----
`timescale 1ns/100ps
module master_clock_gate_wake_tb_top;
    import clock_gate_pkg::*;
    localparam logic [15:0] CFG = 16'h7008;
    localparam logic [15:0] CTL = 16'h700c;
    logic clk = 0;
    logic rst = 1;
    logic [15:0] avs_address = '0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq_a_n, irq_b_n, hw_n, pad, pin_o, pin_oe, alarm, periodic, run;
    logic [14:0] periph_gate;
    logic [14:0] r;
    logic [3:0] src_on = '0;
    logic [1:0] rtc_on = '0;
    logic [31:0] exp_q[$];
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    master_clock_gate_wake u_master_clock_gate_wake (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_irq_a_pin_n(irq_a_n), .ext_irq_b_pin_n(irq_b_n),
        .hw_reset_pin_n(hw_n), .wake_request_pin_i(pad), .wake_request_pin_o(pin_o),
        .wake_request_pin_oe(pin_oe), .rtc_alarm(alarm), .rtc_periodic(periodic), .master_clock_run(run),
        .periph_gate(periph_gate));
    wake_party_model u_wake_party_model (.src_on(src_on), .rtc_on(rtc_on), .pin_oe(pin_oe), .pin_out(pin_o),
        .irq_a_n(irq_a_n), .irq_b_n(irq_b_n), .hw_n(hw_n), .pad(pad), .alarm(alarm), .periodic(periodic));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
        n_tests++;
        if (seen !== expv) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic bus(input logic rd, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            bad_count++;
            wrap_up();
        end
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            check(avs_readdata, exp_q.pop_front(), "readdata");
        end
    end
    initial begin
        void'($urandom(32));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(CFG, 32'h0);
        rd(CTL, 32'h0);
        rd(16'h7100, 32'h0);
        check(run, 32'h1, "run");
        $display("test 1 done");
        r = 15'($urandom);
        bus(1'b0, CFG, {16'h0, 1'b1, r});
        rd(CFG, {16'h0, 1'b1, r});
        check(periph_gate, r, "periph_gate");
        check(run, 32'h0, "run");
        $display("test 2 done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, CFG, {16'h0, 1'b1, r});
            src_on[i] <= 1'b1;
            repeat (4) @(posedge clk);
            rd(CFG, {16'h0, 1'b0, r});
            bus(1'b0, CFG, {16'h0, 1'b1, r});
            rd(CFG, {16'h0, 1'b0, r});
            rd(16'h7010, 32'h40 | (32'h1 << i));
            src_on[i] <= 1'b0;
            repeat (3) @(posedge clk);
        end
        $display("test 3 done");
        for (int k = 0; k < 2; k++) begin
            for (int en = 0; en < 2; en++) begin
                bus(1'b0, CTL, 32'(en << (k + 2)));
                bus(1'b0, CFG, {16'h0, 1'b1, r});
                rtc_on[k] <= 1'b1;
                @(posedge clk);
                rtc_on[k] <= 1'b0;
                rd(CFG, {16'h0, en == 0, r});
            end
        end
        $display("test 4 done");
        bus(1'b0, CTL, 32'h3);
        @(negedge clk);
        check({pin_oe, pin_o}, 32'h3, "pin drive");
        repeat (3) @(posedge clk);
        bus(1'b0, CFG, {16'h0, 1'b1, r});
        rd(CFG, {16'h0, 1'b0, r});
        bus(1'b0, CTL, 32'h1);
        repeat (3) @(posedge clk);
        bus(1'b0, CFG, {16'h0, 1'b1, r});
        rd(CFG, {16'h0, 1'b1, r});
        rd(CTL, 32'h1);
        $display("test 5 done");
        wrap_up();
    end
endmodule
